//--- eth_mac_defs.vh
/*
 Register map, field positions and reset values of the Ethernet MAC control front end.
 Assumes inclusion by bare name from the design files of this folder.
*/
`ifndef ETH_MAC_DEFS_VH
`define ETH_MAC_DEFS_VH
// Region select: host address bits 19:12 of base 0x72000
`define MAC_REGION_PAGE       8'h72
// Register offsets inside the region
`define OFF_NET_CONTROL       12'h000
`define OFF_NET_CONFIGURATION 12'h004
`define OFF_NET_STATE         12'h008
`define OFF_TRANSMITTER_STATE 12'h014
`define OFF_IRQ_STATE         12'h024
`define OFF_IRQ_TURN_ON       12'h028
`define OFF_IRQ_TURN_OFF      12'h02C
`define OFF_IRQ_BLOCK_VIEW    12'h030
`define OFF_PHY_MGMT_FRAME    12'h034
`define OFF_RX_PAUSE_DURATION 12'h038
`define OFF_STATION_ADDR_LOW  12'h098
`define OFF_STATION_ADDR_HIGH 12'h09C
`define OFF_TX_PAUSE_AMOUNT   12'h0BC
`define OFF_SERIAL_PHY_STATE  12'h0C0
`define OFF_STAT_BASE         12'h100
`define STAT_COUNT            8
// Network control fields
`define CTL_ZERO_PAUSE        12
`define CTL_PAUSE             11
`define CTL_BACK_PRESSURE     8
`define CTL_STAT_WRITE        7
`define CTL_STAT_INC          6
`define CTL_STAT_CLR          5
`define CTL_MGMT_EN           4
`define CTL_TX_EN             3
`define CTL_RX_EN             2
`define CTL_STORED_MASK       32'h0000019C
`define CTL_RESET             32'h00000000
// Network configuration fields
`define CFG_FULL_DUPLEX       1
`define CFG_STORED_MASK       32'h000D3D13
`define CFG_RESET             32'h00000800
// Network state and interrupt mask
`define STATE_PHY_IDLE        2
`define IRQ_MASK_RESET        32'hFFFFFFFF
`endif

//--- host_split_access.v
/*
 Split 16-bit access to 32-bit registers: write holding latch, read capture latch,
 registered read data. Assumes one-cycle read and write strobes synchronous to the clock.
*/
`timescale 1ns/100ps
module host_split_access (
	// Clock and reset
	input  wire        core_clk_in,
	input  wire        rstn_in,
	// Host side
	input  wire        bus16_in,
	input  wire        addr_bit1_in,
	input  wire [31:0] wdata_in,
	input  wire        rd_in,
	input  wire        wr_in,
	input  wire [31:0] reg_rdata_in,
	// Register side
	output wire        commit_out,
	output wire [31:0] commit_data_out,
	output reg  [31:0] rdata_out,
	output reg         rvalid_out
);
	reg  [15:0] wlatch_reg;
	reg  [31:0] rlatch_reg;
	wire        upper_half;

	assign upper_half      = bus16_in & addr_bit1_in;
	assign commit_out      = wr_in & ~upper_half;                             // [R4]
	assign commit_data_out = bus16_in ? {wdata_in[15:0], wlatch_reg} : wdata_in; // [R5]

	always @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wlatch_reg <= 16'h0000;
			rlatch_reg <= 32'h00000000;
			rdata_out  <= 32'h00000000;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= rd_in;
			if (wr_in && upper_half)
				wlatch_reg <= wdata_in[15:0];                                   // [R4]
			if (rd_in && upper_half)
				rlatch_reg <= reg_rdata_in;                                     // [R2]
			if (rd_in) begin
				if (!bus16_in)
					rdata_out <= reg_rdata_in;
				else if (addr_bit1_in)
					rdata_out <= {16'h0000, reg_rdata_in[15:0]};                 // [R2]
				else
					rdata_out <= {16'h0000, rlatch_reg[31:16]};                  // [R3]
			end
		end
	end
endmodule // host_split_access

//--- stat_counter_bank.v
/*
 Bank of statistics counters with clear, increment-all, host write and event counting.
 Assumes event inputs are one-cycle pulses from the MAC paths.
*/
`timescale 1ns/100ps
module stat_counter_bank (
	// Clock and reset
	input  wire         core_clk_in,
	input  wire         rstn_in,
	// Control
	input  wire         clear_in,
	input  wire         inc_all_in,
	input  wire [7:0]   event_in,
	input  wire [7:0]   wr_en_in,
	input  wire [31:0]  wdata_in,
	// Counter values
	output wire [255:0] count_flat_out
);
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_cnt
			reg [31:0] cnt_reg;
			always @(posedge core_clk_in or negedge rstn_in) begin
				if (!rstn_in)
					cnt_reg <= 32'h00000000;
				else if (clear_in)
					cnt_reg <= 32'h00000000;                                    // [R11]
				else if (wr_en_in[i])
					cnt_reg <= wdata_in;                                        // [R9]
				else if (inc_all_in || event_in[i])
					cnt_reg <= cnt_reg + 32'h00000001;                          // [R10]
			end
			assign count_flat_out[i*32 +: 32] = cnt_reg;
		end
	endgenerate
endmodule // stat_counter_bank

//--- eth_mac_control_regs.v
/*
 Host-visible control front end of a 10/100 Ethernet MAC: region decode, split access,
 network control with pause requests, statistics controls and port gating.
 Assumes the host strobes are one-cycle pulses synchronous to core_clk_in and that the
 MAC transmit, receive and PHY management engines sit outside this module.
*/
`timescale 1ns/100ps
`include "eth_mac_defs.vh"

// Operation
// R1 - Decode MAC registers in the fixed region at 0x72000, each at its offset.
// R2 - 16-bit mode read at upper half latches whole word, returns low half.
// R3 - Following read at lower half returns the latched upper sixteen bits.
// R4 - 16-bit mode write at upper half only latches low data bits.
// R5 - Next lower-half write updates the whole register from bus and latch.
// R6 - Zero-pause request bit sends zero-quantum pause frame at next transmitter idle.
// R7 - Pause request bit sends pause frame with stored quantum at next idle.
// R8 - Back pressure in half duplex forces collision on every received packet.
// R9 - Statistics write-permit bit makes counters host writable, otherwise not.
// R10 - Statistics increment bit adds one to every counter at once.
// R11 - Statistics clear bit zeroes every counter.
// R12 - Management port disabled holds MDIO released and MDC low.
// R13 - Clearing transmit enable stops transmit, flushes FIFO, rewinds queue pointer.
// R14 - Software keeps transmit enable set; transmitter sends only while it is one.
// R15 - Receive enable clear stops reception; set lets receiver accept data.
// R16 - Upper control bits read zero and ignore writes.
// R17 - Software writes zero to unused control bits 10:9 and 1:0.
// R18 - Pause request stays pending until idle, cleared once the frame is sent.
module eth_mac_control_regs (
	// Clock and reset
	input  wire        core_clk_in,
	input  wire        rstn_in,
	// Host processor bus
	input  wire        bus16_mode_in,
	input  wire [19:0] host_addr_in,
	input  wire [31:0] host_wdata_in,
	input  wire        host_rd_in,
	input  wire        host_wr_in,
	output wire [31:0] host_rdata_out,
	output wire        host_rvalid_out,
	// Transmit path
	input  wire        tx_idle_in,
	input  wire        pause_sent_in,
	output wire        tx_enable_out,
	output reg         tx_flush_out,
	output wire        pause_send_out,
	output wire [15:0] pause_quantum_out,
	// Receive path
	input  wire        rx_active_in,
	output wire        rx_enable_out,
	output wire        force_collision_out,
	// Status from the MAC
	input  wire [31:0] transmitter_state_in,
	input  wire [31:0] irq_state_in,
	input  wire [31:0] rx_pause_duration_in,
	input  wire [31:0] serial_phy_state_in,
	input  wire        phy_idle_in,
	input  wire [7:0]  stat_event_in,
	// Configuration to the MAC
	output wire [31:0] net_configuration_out,
	output wire [31:0] irq_mask_out,
	output wire [47:0] station_addr_out,
	output wire [31:0] phy_mgmt_frame_out,
	output reg         phy_mgmt_start_out,
	// PHY management pins
	input  wire        mdc_raw_in,
	input  wire        mdio_raw_out_in,
	input  wire        mdio_raw_oe_in,
	input  wire        mdio_in,
	output wire        mdc_out,
	output wire        mdio_out,
	output wire        mdio_oe_out,
	output wire        mdio_sample_out
);
	// Decoded write and read
	wire         in_region;
	wire [11:0]  offset;
	wire         commit;
	wire [31:0]  wdata;
	reg  [31:0]  rd_word;

	// Stored registers
	reg  [31:0]  net_control_reg;
	reg  [31:0]  net_configuration_reg;
	reg  [31:0]  irq_mask_reg;
	reg  [31:0]  phy_mgmt_frame_reg;
	reg  [31:0]  station_addr_low_reg;
	reg  [15:0]  station_addr_high_reg;
	reg  [15:0]  tx_pause_amount_reg;

	// Pause request state
	reg          pause_pend_reg;
	reg          zero_pause_pend_reg;
	wire         pause_go;

	// Statistics
	wire         stat_clear;
	wire         stat_inc;
	wire [7:0]   stat_wr_en;
	wire [255:0] stat_flat;

	function hit;
		input [11:0] off;
		input [11:0] target;
		begin
			hit = (off == target);
		end
	endfunction

	// Region decode; addresses outside the MAC page are left alone
	assign in_region = (host_addr_in[19:12] == `MAC_REGION_PAGE);               // [R1]
	assign offset    = {host_addr_in[11:2], 2'b00};

	host_split_access u_split (
		.core_clk_in     (core_clk_in),
		.rstn_in         (rstn_in),
		.bus16_in        (bus16_mode_in),
		.addr_bit1_in    (host_addr_in[1]),
		.wdata_in        (host_wdata_in),
		.rd_in           (host_rd_in),
		.wr_in           (host_wr_in & in_region),
		.reg_rdata_in    (rd_word),
		.commit_out      (commit),
		.commit_data_out (wdata),
		.rdata_out       (host_rdata_out),
		.rvalid_out      (host_rvalid_out)
	);

	// Read multiplexer, unmapped offsets read as zero
	always @* begin
		rd_word = 32'h00000000;
		if (in_region) begin
			if (hit(offset, `OFF_NET_CONTROL))
				rd_word = net_control_reg & `CTL_STORED_MASK;                      // [R16]
			else if (hit(offset, `OFF_NET_CONFIGURATION))
				rd_word = net_configuration_reg;
			else if (hit(offset, `OFF_NET_STATE))
				rd_word = {29'h00000000, phy_idle_in, 2'b00};
			else if (hit(offset, `OFF_TRANSMITTER_STATE))
				rd_word = transmitter_state_in;
			else if (hit(offset, `OFF_IRQ_STATE))
				rd_word = irq_state_in;
			else if (hit(offset, `OFF_IRQ_BLOCK_VIEW))
				rd_word = irq_mask_reg;
			else if (hit(offset, `OFF_PHY_MGMT_FRAME))
				rd_word = phy_mgmt_frame_reg;
			else if (hit(offset, `OFF_RX_PAUSE_DURATION))
				rd_word = rx_pause_duration_in;
			else if (hit(offset, `OFF_STATION_ADDR_LOW))
				rd_word = station_addr_low_reg;
			else if (hit(offset, `OFF_STATION_ADDR_HIGH))
				rd_word = {16'h0000, station_addr_high_reg};
			else if (hit(offset, `OFF_TX_PAUSE_AMOUNT))
				rd_word = {16'h0000, tx_pause_amount_reg};
			else if (hit(offset, `OFF_SERIAL_PHY_STATE))
				rd_word = serial_phy_state_in;
			else if (offset[11:5] == `OFF_STAT_BASE >> 5)
				rd_word = stat_flat[offset[4:2]*32 +: 32];
		end
	end

	// Stored control and configuration
	always @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			net_control_reg       <= `CTL_RESET;
			net_configuration_reg <= `CFG_RESET;
			irq_mask_reg          <= `IRQ_MASK_RESET;
			phy_mgmt_frame_reg    <= 32'h00000000;
			station_addr_low_reg  <= 32'h00000000;
			station_addr_high_reg <= 16'h0000;
			tx_pause_amount_reg   <= 16'h0000;
			phy_mgmt_start_out    <= 1'b0;
		end else begin
			phy_mgmt_start_out <= 1'b0;
			if (commit) begin
				// Only the stored fields keep their value; the rest are dropped
				if (hit(offset, `OFF_NET_CONTROL))
					net_control_reg <= wdata & `CTL_STORED_MASK;                    // [R16]
				if (hit(offset, `OFF_NET_CONFIGURATION))
					net_configuration_reg <= wdata & `CFG_STORED_MASK;
				if (hit(offset, `OFF_IRQ_TURN_ON))
					irq_mask_reg <= irq_mask_reg & ~wdata;
				if (hit(offset, `OFF_IRQ_TURN_OFF))
					irq_mask_reg <= irq_mask_reg | wdata;
				if (hit(offset, `OFF_PHY_MGMT_FRAME)) begin
					phy_mgmt_frame_reg <= wdata;
					phy_mgmt_start_out <= 1'b1;
				end
				if (hit(offset, `OFF_STATION_ADDR_LOW))
					station_addr_low_reg <= wdata;
				if (hit(offset, `OFF_STATION_ADDR_HIGH))
					station_addr_high_reg <= wdata[15:0];
				if (hit(offset, `OFF_TX_PAUSE_AMOUNT))
					tx_pause_amount_reg <= wdata[15:0];
			end
		end
	end

	// Write-only command bits of network control
	wire ctl_write;
	assign ctl_write = commit & hit(offset, `OFF_NET_CONTROL);

	// Pause requests wait for idle; a new request in the send cycle is kept
	assign pause_go       = (pause_pend_reg | zero_pause_pend_reg) & tx_idle_in;   // [R18]
	assign pause_send_out = pause_go;                                           // [R6] [R7]
	// Normal pause goes first when both wait; its quantum is chosen without a register stage
	assign pause_quantum_out = pause_pend_reg ? tx_pause_amount_reg : 16'h0000; // [R6] [R7]

	always @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pause_pend_reg      <= 1'b0;
			zero_pause_pend_reg <= 1'b0;
		end else begin
			// Clear on completion first so that a fresh request in the same cycle wins
			if (pause_sent_in) begin
				if (pause_pend_reg)
					pause_pend_reg <= 1'b0;                                        // [R18]
				else
					zero_pause_pend_reg <= 1'b0;                                   // [R18]
			end
			if (ctl_write && wdata[`CTL_PAUSE])
				pause_pend_reg <= 1'b1;                                            // [R7]
			if (ctl_write && wdata[`CTL_ZERO_PAUSE])
				zero_pause_pend_reg <= 1'b1;                                       // [R6]
		end
	end

	// Transmit flush pulse on the enable falling
	always @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			tx_flush_out <= 1'b0;
		else
			tx_flush_out <= ctl_write & net_control_reg[`CTL_TX_EN] &
				~wdata[`CTL_TX_EN];                                                 // [R13]
	end

	assign tx_enable_out = net_control_reg[`CTL_TX_EN];                         // [R13] [R14]
	assign rx_enable_out = net_control_reg[`CTL_RX_EN];                         // [R15]

	// Collision forcing only makes sense in half duplex
	assign force_collision_out = net_control_reg[`CTL_BACK_PRESSURE] &
		~net_configuration_reg[`CFG_FULL_DUPLEX] & rx_active_in;                 // [R8]

	// Statistics controls
	assign stat_clear = ctl_write & wdata[`CTL_STAT_CLR];                       // [R11]
	assign stat_inc   = ctl_write & wdata[`CTL_STAT_INC];                       // [R10]

	genvar k;
	generate
		for (k = 0; k < `STAT_COUNT; k = k + 1) begin : g_stat_wr
			assign stat_wr_en[k] = commit & net_control_reg[`CTL_STAT_WRITE] &
				hit(offset, `OFF_STAT_BASE + k * 4);                                // [R9]
		end
	endgenerate

	stat_counter_bank u_stats (
		.core_clk_in    (core_clk_in),
		.rstn_in        (rstn_in),
		.clear_in       (stat_clear),
		.inc_all_in     (stat_inc),
		.event_in       (stat_event_in),
		.wr_en_in       (stat_wr_en),
		.wdata_in       (wdata),
		.count_flat_out (stat_flat)
	);

	// PHY management gating; MDC held low and MDIO released when disabled
	assign mdc_out         = net_control_reg[`CTL_MGMT_EN] & mdc_raw_in;        // [R12]
	assign mdio_oe_out     = net_control_reg[`CTL_MGMT_EN] & mdio_raw_oe_in;    // [R12]
	assign mdio_out        = net_control_reg[`CTL_MGMT_EN] & mdio_raw_out_in;
	assign mdio_sample_out = mdio_in;

	// Configuration outputs
	assign net_configuration_out = net_configuration_reg;
	assign irq_mask_out          = irq_mask_reg;
	assign station_addr_out      = {station_addr_high_reg, station_addr_low_reg};
	assign phy_mgmt_frame_out    = phy_mgmt_frame_reg;
endmodule // eth_mac_control_regs

//--- mac_ctl_properties.sv
/* Concurrent checks on the MAC control front end ports.
 Assumes binding to eth_mac_control_regs, one clock domain. */
`timescale 1ns/100ps
module mac_ctl_properties (
	input wire        core_clk_in,
	input wire        rstn_in,
	input wire        bus16_mode_in,
	input wire [19:0] host_addr_in,
	input wire [31:0] host_wdata_in,
	input wire        host_rd_in,
	input wire        host_wr_in,
	input wire        host_rvalid_out,
	input wire        tx_idle_in,
	input wire        pause_sent_in,
	input wire        tx_enable_out,
	input wire        tx_flush_out,
	input wire        pause_send_out,
	input wire        rx_active_in,
	input wire        rx_enable_out,
	input wire        force_collision_out,
	input wire [31:0] net_configuration_out,
	input wire [47:0] station_addr_out,
	input wire        mdc_out,
	input wire        mdio_oe_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	wire ctl_wr = host_wr_in && !bus16_mode_in && host_addr_in == 20'h72000;
	sequence s_pause_req; ctl_wr && host_wdata_in[11]; endsequence
	sequence s_half_wr; host_wr_in && bus16_mode_in && host_addr_in[1]; endsequence
	AST_RD_ANSWER: assert property (host_rd_in |=> host_rvalid_out)
		else $error("read not answered");
	AST_TX_EN: assert property (ctl_wr |=> tx_enable_out == $past(host_wdata_in[3]))
		else $error("transmit enable wrong");
	AST_RX_EN: assert property (ctl_wr |=> rx_enable_out == $past(host_wdata_in[2]))
		else $error("receive enable wrong");
	AST_FLUSH: assert property ($fell(tx_enable_out) |-> ##[0:1] tx_flush_out)
		else $error("no flush on transmit stop");
	AST_COLL: assert property (force_collision_out |-> rx_active_in && !net_configuration_out[1])
		else $error("collision forced wrongly");
	AST_MGMT_OFF: assert property (ctl_wr && !host_wdata_in[4] |=> !mdc_out && !mdio_oe_out)
		else $error("management port not idle");
	AST_PAUSE_IDLE: assert property (pause_send_out |-> tx_idle_in)
		else $error("pause sent while busy");
	AST_PAUSE_GO: assert property (s_pause_req ##1 tx_idle_in |-> pause_send_out)
		else $error("pause request lost");
	AST_PAUSE_HOLD: assert property (pause_send_out && !pause_sent_in |=> pause_send_out || !tx_idle_in)
		else $error("pending pause dropped");
	AST_HALF_WR: assert property (s_half_wr |=> $stable(tx_enable_out) && $stable(station_addr_out))
		else $error("upper half write changed register");
endmodule // mac_ctl_properties

bind eth_mac_control_regs mac_ctl_properties i_props (.core_clk_in, .rstn_in, .bus16_mode_in,
	.host_addr_in, .host_wdata_in, .host_rd_in, .host_wr_in, .host_rvalid_out, .tx_idle_in,
	.pause_sent_in, .tx_enable_out, .tx_flush_out, .pause_send_out, .rx_active_in,
	.rx_enable_out, .force_collision_out, .net_configuration_out, .station_addr_out,
	.mdc_out, .mdio_oe_out);

//--- mac_tx_model.sv
/* Transmit engine stand-in: idle unless held or sending a pause frame.
 Assumes hold_in from the bench stands for an ongoing transmission. */
`timescale 1ns/100ps
module mac_tx_model #(parameter int SEND_CYCLES = 4) (
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic rstn_in,
	// Control
	input  wire logic hold_in,
	input  wire logic pause_send_in,
	output logic      tx_idle_out,
	output logic      pause_sent_out
);
	logic [3:0] cnt_reg;
	assign tx_idle_out = !hold_in && cnt_reg == 4'h0;
	// Pulse one cycle before going idle, so the request is gone when idle returns
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_reg <= 4'h0;
			pause_sent_out <= 1'b0;
		end else begin
			pause_sent_out <= cnt_reg == 4'h2;
			if (cnt_reg != 4'h0)
				cnt_reg <= cnt_reg - 4'h1;
			else if (pause_send_in && tx_idle_out)
				cnt_reg <= 4'(SEND_CYCLES);
		end
	end
endmodule // mac_tx_model

//--- tb_top.sv
/* Self-checking bench for eth_mac_control_regs.
 Assumes mac_tx_model and the bound checker are compiled before it. */
`timescale 1ns/100ps
module tb_top;
	logic        core_clk_in = 1'b0;
	logic        rstn_in     = 1'b0;
	logic        b16 = 1'b0, rd = 1'b0, wr = 1'b0, hold = 1'b0, rx_act = 1'b0;
	logic        raw = 1'b1, phy_idle = 1'b1;
	logic [19:0] addr = 20'h00000;
	logic [31:0] wd = 32'h00000000, st = 32'h13579BDF;
	logic [31:0] rdata, cfg;
	logic [47:0] sta;
	logic [15:0] quant;
	logic        rvalid, tx_en, flush, psend, idle, psent, rx_en, coll, mdc, oe;
	int          n_fail = 0, n_checks = 0;

	always #5 core_clk_in = ~core_clk_in;

	eth_mac_control_regs i_dut (.core_clk_in, .rstn_in, .bus16_mode_in(b16),
		.host_addr_in(addr), .host_wdata_in(wd), .host_rd_in(rd), .host_wr_in(wr),
		.host_rdata_out(rdata), .host_rvalid_out(rvalid), .tx_idle_in(idle),
		.pause_sent_in(psent), .tx_enable_out(tx_en), .tx_flush_out(flush),
		.pause_send_out(psend), .pause_quantum_out(quant), .rx_active_in(rx_act),
		.rx_enable_out(rx_en), .force_collision_out(coll), .transmitter_state_in(st),
		.irq_state_in(~st), .rx_pause_duration_in(st), .serial_phy_state_in(~st),
		.phy_idle_in(phy_idle), .stat_event_in(8'h00), .net_configuration_out(cfg),
		.irq_mask_out(), .station_addr_out(sta), .phy_mgmt_frame_out(),
		.phy_mgmt_start_out(), .mdc_raw_in(raw), .mdio_raw_out_in(raw),
		.mdio_raw_oe_in(raw), .mdio_in(raw), .mdc_out(mdc), .mdio_out(), .mdio_oe_out(oe),
		.mdio_sample_out());

	mac_tx_model #(.SEND_CYCLES(3)) i_tx (.core_clk_in, .rstn_in, .hold_in(hold),
		.pause_send_in(psend), .tx_idle_out(idle), .pause_sent_out(psent));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle strobe; read data is looked at in the cycle of its valid pulse
	task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d);
		@(negedge core_clk_in);
		addr = a;
		wd = d;
		wr = w;
		rd = !w;
		@(negedge core_clk_in);
		wr = 1'b0;
		rd = 1'b0;
		if (!w) chk(32'(rvalid), 32'h1);
	endtask

	task automatic rdc(input logic [19:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask

	// Bounded wait for the frame to finish, then the request must be gone
	task automatic wait_sent;
		for (int i = 0; i < 20 && psent !== 1'b1; i++) @(negedge core_clk_in);
		chk(32'(psent), 32'h1);
		@(negedge core_clk_in);
		chk(32'(psend), 32'h0);
	endtask

	task automatic give_verdict;
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#100us;
		n_fail++;
		give_verdict();
	end

	initial begin
		repeat (8) @(negedge core_clk_in);
		rstn_in = 1'b1;
		rdc(20'h72000, 32'h0);
		rdc(20'h72004, 32'h800);
		rdc(20'h72030, 32'hFFFFFFFF);
		rdc(20'h72008, 32'h4);
		rdc(20'h72014, st);
		rdc(20'h720C0, ~st);
		rdc(20'h72050, 32'h0);
		rdc(20'h72024, ~st);
		rdc(20'h72038, st);
		acc(1'b1, 20'h72028, 32'h0000000F);
		rdc(20'h72030, 32'hFFFFFFF0);
		acc(1'b1, 20'h7202C, 32'h00000003);
		rdc(20'h72030, 32'hFFFFFFF3);
		acc(1'b1, 20'h72034, 32'h5A5A1234);
		rdc(20'h72034, 32'h5A5A1234);
		rdc(20'h71000, 32'h0);
		acc(1'b1, 20'h72000, 32'hFFFFE19C);
		chk(32'({tx_en, rx_en}), 32'h3);
		rdc(20'h72000, 32'h19C);
		rx_act = 1'b1;
		#1 chk(32'(coll), 32'h1);
		acc(1'b1, 20'h72004, 32'h802);
		chk(32'(coll), 32'h0);
		acc(1'b1, 20'h72004, 32'h800);
		rx_act = 1'b0;
		chk(32'({mdc, oe}), 32'h3);
		acc(1'b1, 20'h72000, 32'h0C);
		chk(32'({mdc, oe}), 32'h0);
		acc(1'b1, 20'h72100, 32'h55);
		rdc(20'h72100, 32'h0);
		acc(1'b1, 20'h72000, 32'h8C);
		acc(1'b1, 20'h72100, 32'h55);
		rdc(20'h72100, 32'h55);
		acc(1'b1, 20'h72000, 32'hCC);
		rdc(20'h72100, 32'h56);
		rdc(20'h7211C, 32'h1);
		acc(1'b1, 20'h72000, 32'hAC);
		rdc(20'h72100, 32'h0);
		rdc(20'h7211C, 32'h0);
		acc(1'b1, 20'h72000, 32'h04);
		chk(32'({flush, tx_en}), 32'h2);
		@(negedge core_clk_in);
		chk(32'(flush), 32'h0);
		acc(1'b1, 20'h720BC, 32'h1234);
		rdc(20'h720BC, 32'h1234);
		hold = 1'b1;
		acc(1'b1, 20'h72000, 32'h80C);
		repeat (3) @(negedge core_clk_in);
		chk(32'(psend), 32'h0);
		hold = 1'b0;
		#1 chk({psend, quant}, 32'h11234);
		wait_sent();
		hold = 1'b1;
		acc(1'b1, 20'h72000, 32'h100C);
		hold = 1'b0;
		#1 chk({psend, quant}, 32'h10000);
		wait_sent();
		b16 = 1'b1;
		acc(1'b1, 20'h7209A, 32'hBEEF);
		chk(sta[31:0], 32'h0);
		acc(1'b1, 20'h72098, 32'hCAFE);
		chk(sta[31:0], 32'hCAFEBEEF);
		rdc(20'h7209A, 32'hBEEF);
		rdc(20'h72098, 32'hCAFE);
		give_verdict();
	end
endmodule // tb_top
